// ===== rcr_params.svh
`ifndef RCR_PARAMS_SVH
`define RCR_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OFS_FLAGS     8'h00
`define OFS_STATUS    8'h04
`define OFS_EVT       8'h08
`define OFS_MASK      8'h0c
`define OFS_LAST      8'h10

// ----------------------------------------------------------------------
// Cause flag bits
// ----------------------------------------------------------------------
`define BIT_OVF       7
`define BIT_UNF       6
`define BIT_GAP       5
`define BIT_WDT       4
`define BIT_PIN       3
`define BIT_INSTR     2
`define BIT_POR       1
`define BIT_BROWN     0
`define FLAGS_RST     8'h1c
`define FLAGS_WMASK   8'hdf

// ----------------------------------------------------------------------
// Sleep status bits
// ----------------------------------------------------------------------
`define BIT_TIMEOUT   4
`define BIT_PWRDN     3

// ----------------------------------------------------------------------
// Event bits (interrupt status, mask, last event)
// ----------------------------------------------------------------------
`define EV_BROWN      0
`define EV_WDR        1
`define EV_WWK        2
`define EV_IWK        3
`define EV_PIN        4
`define EV_INS        5
`define EV_OVF        6
`define EV_UNF        7

// ----------------------------------------------------------------------
// Program counter targets and pin sync reset levels
// ----------------------------------------------------------------------
`define VEC_RESET     16'h0000
`define VEC_IRQ       16'h0004
`define SYNC_RST      3'h4

`endif

// ===== rcr_pkg.sv
package rcr_pkg;

    typedef enum logic [3:0] {
        ACT_IDLE = 4'h1,
        ACT_ZERO = 4'h2,
        ACT_NEXT = 4'h4,
        ACT_VEC  = 4'h8
    } pc_action_e;

    typedef struct packed {
        pc_action_e  action;
        logic [15:0] addr;
    } pc_ctl_s;

    typedef struct packed {
        logic asleep;
        logic wdt_timeout;
        logic irq_wake;
        logic reset_instr;
        logic stack_over;
        logic stack_under;
    } core_evt_s;

endpackage : rcr_pkg

// ===== pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // System
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Pins and filtered levels
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic s1_r;
            logic s2_r;
            logic s3_r;
            // Level moves only once the last two stages agree
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    s1_r     <= RST_VAL[g];
                    s2_r     <= RST_VAL[g];
                    s3_r     <= RST_VAL[g];
                    q_o[g]   <= RST_VAL[g];
                end else begin
                    s1_r <= d_i[g];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    if (s2_r == s3_r) begin
                        q_o[g] <= s3_r;
                    end
                end
            end
        end
    endgenerate

endmodule : pin_sync

`default_nettype wire

// ===== reset_cause_recorder.sv
// Notes on behaviour
// - Every reset event updates its cause flag; only some update status bits
// - Power-on: sleep bits set, cause flags to defaults
// - Power-on flag reads zero until firmware sets it
// - Brown-out clears its flag, sets pin/instr flags
// - Watchdog reset clears its flag and time-out
// - Watchdog wake clears both sleep bits only
// - Interrupt wake sets time-out, clears power-down
// - Interrupt wake with enable vectors at once to VEC_IRQ
// - Pin reset clears pin flag; in sleep adjusts
// - Reset instruction clears its flag, restarts zero
// - Enabled stack overflow sets overflow flag
// - Enabled stack underflow sets underflow flag
// - Firmware re-arms flags; hardware one direction only, except brown-out
// - Bit five unimplemented, always reads zero
// - Resets restart at zero, wakes continue except an enabled interrupt wake
// - Brown-out is OR of both detectors
//
// Design decisions made here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "rcr_params.svh"

module reset_cause_recorder (
    // System
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone slave
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [7:0]        adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    output logic                   ack_o,
    // Reset sources
    input  wire logic              brownout_det_i,
    input  wire logic              low_power_brownout_i,
    input  wire logic              external_reset_pin_n_i,
    input  wire rcr_pkg::core_evt_s core_i,
    input  wire logic              stack_reset_enable_i,
    input  wire logic              global_irq_enable_i,
    // Results
    output logic      [7:0]        flags_o,
    output logic                   time_out_bit_o,
    output logic                   power_down_bit_o,
    output rcr_pkg::pc_ctl_s       pc_ctl_o,
    output logic                   irq_o
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    logic        ack_r;
    logic        wr_go;
    logic        wr_flags;
    logic        wr_evt;
    logic        wr_mask;
    logic [7:0]  wdat;

    assign ack_o    = ack_r;
    // Writes commit on the same edge at which the master sees ack
    assign wr_go    = cyc_i & stb_i & we_i & ack_r & sel_i[0];
    assign wr_flags = wr_go & hit(adr_i, `OFS_FLAGS);
    assign wr_evt   = wr_go & hit(adr_i, `OFS_EVT);
    assign wr_mask  = wr_go & hit(adr_i, `OFS_MASK);
    assign wdat     = dat_i[7:0];

    // ------------------------------------------------------------------
    // Pin inputs
    // ------------------------------------------------------------------
    logic [2:0] pins_q;
    logic       bo_lvl;
    logic       pin_lvl;
    logic       bo_prev_r;
    logic       pin_prev_r;

    pin_sync #(
        .W       (3),
        .RST_VAL (`SYNC_RST)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({external_reset_pin_n_i, low_power_brownout_i,
                 brownout_det_i}),
        .q_o   (pins_q)
    );

    assign bo_lvl  = pins_q[0] | pins_q[1];
    assign pin_lvl = ~pins_q[2];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bo_prev_r  <= 1'b0;
            pin_prev_r <= 1'b0;
        end else begin
            bo_prev_r  <= bo_lvl;
            pin_prev_r <= pin_lvl;
        end
    end

    // ------------------------------------------------------------------
    // Events
    // ------------------------------------------------------------------
    logic [7:0] ev;
    logic       restart;

    always_comb begin
        ev              = 8'h00;
        ev[`EV_BROWN]   = bo_lvl & ~bo_prev_r;
        ev[`EV_PIN]     = pin_lvl & ~pin_prev_r;
        ev[`EV_WDR]     = core_i.wdt_timeout & ~core_i.asleep;
        ev[`EV_WWK]     = core_i.wdt_timeout & core_i.asleep;
        ev[`EV_IWK]     = core_i.irq_wake & core_i.asleep;
        ev[`EV_INS]     = core_i.reset_instr;
        ev[`EV_OVF]     = core_i.stack_over & stack_reset_enable_i;
        ev[`EV_UNF]     = core_i.stack_under & stack_reset_enable_i;
    end

    assign restart = ev[`EV_BROWN] | ev[`EV_WDR] | ev[`EV_PIN] |
                     ev[`EV_INS] | ev[`EV_OVF] | ev[`EV_UNF];

    // ------------------------------------------------------------------
    // Cause flags
    // ------------------------------------------------------------------
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;

    // Firmware value first, then each event in turn on top of it
    always_comb begin
        flags_nxt = flags_r;
        if (wr_flags) begin
            flags_nxt = (flags_r & ~`FLAGS_WMASK) |
                        (wdat & `FLAGS_WMASK);
        end
        if (ev[`EV_BROWN]) begin
            flags_nxt[`BIT_BROWN] = 1'b0;
            flags_nxt[`BIT_PIN]   = 1'b1;
            flags_nxt[`BIT_INSTR] = 1'b1;
            flags_nxt[`BIT_OVF]   = 1'b0;
            flags_nxt[`BIT_UNF]   = 1'b0;
        end
        if (ev[`EV_WDR]) begin
            flags_nxt[`BIT_WDT] = 1'b0;
        end
        if (ev[`EV_PIN]) begin
            flags_nxt[`BIT_PIN] = 1'b0;
        end
        if (ev[`EV_INS]) begin
            flags_nxt[`BIT_INSTR] = 1'b0;
        end
        if (ev[`EV_OVF]) begin
            flags_nxt[`BIT_OVF] = 1'b1;
        end
        if (ev[`EV_UNF]) begin
            flags_nxt[`BIT_UNF] = 1'b1;
        end
        flags_nxt[`BIT_GAP] = 1'b0;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_r <= `FLAGS_RST;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign flags_o = flags_r;

    // ------------------------------------------------------------------
    // Sleep status bits
    // ------------------------------------------------------------------
    logic to_r;
    logic pwrdn_r;
    logic to_nxt;
    logic pwrdn_nxt;

    always_comb begin
        to_nxt    = to_r;
        pwrdn_nxt = pwrdn_r;
        if (ev[`EV_BROWN]) begin
            to_nxt    = 1'b1;
            pwrdn_nxt = 1'b1;
        end
        if (ev[`EV_WDR]) begin
            to_nxt = 1'b0;
        end
        if (ev[`EV_WWK]) begin
            to_nxt    = 1'b0;
            pwrdn_nxt = 1'b0;
        end
        if (ev[`EV_IWK]) begin
            to_nxt    = 1'b1;
            pwrdn_nxt = 1'b0;
        end
        if (ev[`EV_PIN] && core_i.asleep) begin
            to_nxt    = 1'b1;
            pwrdn_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            to_r    <= 1'b1;
            pwrdn_r <= 1'b1;
        end else begin
            to_r    <= to_nxt;
            pwrdn_r <= pwrdn_nxt;
        end
    end

    assign time_out_bit_o   = to_r;
    assign power_down_bit_o = pwrdn_r;

    // ------------------------------------------------------------------
    // Program counter control
    // ------------------------------------------------------------------
    rcr_pkg::pc_ctl_s pc_r;

    // A reset outranks a wake arriving in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_r.action <= rcr_pkg::ACT_IDLE;
            pc_r.addr   <= `VEC_RESET;
        end else if (restart) begin
            pc_r.action <= rcr_pkg::ACT_ZERO;
            pc_r.addr   <= `VEC_RESET;
        end else if (ev[`EV_IWK] && global_irq_enable_i) begin
            pc_r.action <= rcr_pkg::ACT_VEC;
            pc_r.addr   <= `VEC_IRQ;
        end else if (ev[`EV_IWK] || ev[`EV_WWK]) begin
            pc_r.action <= rcr_pkg::ACT_NEXT;
            pc_r.addr   <= `VEC_RESET;
        end else begin
            pc_r.action <= rcr_pkg::ACT_IDLE;
            pc_r.addr   <= `VEC_RESET;
        end
    end

    assign pc_ctl_o = pc_r;

    // ------------------------------------------------------------------
    // Interrupt status, mask and last event
    // ------------------------------------------------------------------
    logic [7:0] evt_r;
    logic [7:0] mask_r;
    logic [7:0] last_r;

    // A new event wins over a write-one-to-clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_r <= 8'h00;
        end else begin
            evt_r <= (evt_r & ~(wr_evt ? wdat : 8'h00)) | ev;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_r <= 8'h00;
        end else if (wr_mask) begin
            mask_r <= wdat;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_r <= 8'h00;
        end else if (|ev) begin
            last_r <= ev;
        end
    end

    assign irq_o = |(evt_r & mask_r);

    // ------------------------------------------------------------------
    // Wishbone answer
    // ------------------------------------------------------------------
    logic [7:0] rd_byte;

    always_comb begin
        if (hit(adr_i, `OFS_FLAGS)) begin
            rd_byte = flags_r;
        end else if (hit(adr_i, `OFS_STATUS)) begin
            rd_byte = 8'h00;
            rd_byte[`BIT_TIMEOUT] = to_r;
            rd_byte[`BIT_PWRDN]   = pwrdn_r;
        end else if (hit(adr_i, `OFS_EVT)) begin
            rd_byte = evt_r;
        end else if (hit(adr_i, `OFS_MASK)) begin
            rd_byte = mask_r;
        end else if (hit(adr_i, `OFS_LAST)) begin
            rd_byte = last_r;
        end else begin
            rd_byte = 8'h00;
        end
    end

    // Ack after one cycle; drops the cycle after it was given
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= cyc_i & stb_i & ~ack_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (cyc_i && stb_i && !ack_r) begin
            dat_o <= {24'h00_0000, rd_byte};
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic only_wwk;
    logic only_iwk;
    assign only_wwk = (ev == (8'h01 << `EV_WWK)) && !wr_flags;
    assign only_iwk = (ev == (8'h01 << `EV_IWK)) && !wr_flags;

    sequence s_iwk_vec;
        ev[`EV_IWK] && !restart && global_irq_enable_i;
    endsequence
    sequence s_vec_issued;
        pc_ctl_o.action == rcr_pkg::ACT_VEC && pc_ctl_o.addr == `VEC_IRQ
        ##1 pc_ctl_o.action != rcr_pkg::ACT_VEC || $past(ev[`EV_IWK]);
    endsequence

    AST_POR_VALUES: assert property (
        $past(rst_i) |-> flags_r == `FLAGS_RST && to_r && pwrdn_r
    ) else $error("power-on values wrong");
    AST_POR_HOLD: assert property (
        !flags_r[`BIT_POR] && !(wr_flags && wdat[`BIT_POR])
        |=> !flags_r[`BIT_POR]
    ) else $error("power-on flag rose without a write");
    AST_BROWN_UPDATE: assert property (
        ev[`EV_BROWN] && !ev[`EV_PIN] && !ev[`EV_INS] && !ev[`EV_WDR]
        && !ev[`EV_OVF] && !ev[`EV_UNF] && !ev[`EV_WWK] && !ev[`EV_IWK]
        |=> flags_r[7:6] == 2'b00 && !flags_r[`BIT_BROWN]
            && flags_r[`BIT_PIN] && flags_r[`BIT_INSTR] && to_r && pwrdn_r
    ) else $error("brown-out update wrong");
    AST_WDT_RESET: assert property (
        ev[`EV_WDR] && !ev[`EV_BROWN] |=> !flags_r[`BIT_WDT] && !to_r
    ) else $error("watchdog reset update wrong");
    AST_WDT_WAKE: assert property (
        only_wwk |=> !to_r && !pwrdn_r && $stable(flags_r)
            && pc_ctl_o.action == rcr_pkg::ACT_NEXT
    ) else $error("watchdog wake update wrong");
    AST_IRQ_WAKE: assert property (
        only_iwk |=> to_r && !pwrdn_r && $stable(flags_r)
    ) else $error("interrupt wake update wrong");
    AST_VECTOR: assert property (
        s_iwk_vec |=> s_vec_issued
    ) else $error("interrupt vector not issued");
    AST_PIN_RESET: assert property (
        ev[`EV_PIN] && core_i.asleep && !ev[`EV_WWK]
        |=> !flags_r[`BIT_PIN] && to_r && !pwrdn_r
    ) else $error("pin reset update wrong");
    AST_INSTR_RESET: assert property (
        ev[`EV_INS] |=> !flags_r[`BIT_INSTR]
            && pc_ctl_o.action == rcr_pkg::ACT_ZERO
    ) else $error("reset instruction update wrong");
    AST_STACK_GATE: assert property (
        core_i.stack_over && !stack_reset_enable_i && !wr_flags
        && !ev[`EV_BROWN] |=> $stable(flags_r[`BIT_OVF])
    ) else $error("stack flag moved while disabled");
    AST_UNDER_SET: assert property (
        ev[`EV_UNF] |=> flags_r[`BIT_UNF] && pc_ctl_o.addr == `VEC_RESET
    ) else $error("underflow flag not set");
    AST_HW_CLEAR_ONLY: assert property (
        !wr_flags && !ev[`EV_BROWN] |=> !$rose(flags_r[`BIT_WDT])
            && !$fell(flags_r[`BIT_OVF])
    ) else $error("hardware moved a flag the wrong way");
    AST_GAP_ZERO: assert property (
        wr_flags && wdat[`BIT_GAP] |=> !flags_o[`BIT_GAP]
    ) else $error("unimplemented bit stored");
    AST_RESTART_ZERO: assert property (
        restart |=> pc_ctl_o.action == rcr_pkg::ACT_ZERO
            ##1 pc_ctl_o.action != rcr_pkg::ACT_ZERO || $past(restart)
    ) else $error("restart not issued");
    AST_BO_EITHER: assert property (
        $rose(bo_lvl) |-> ev[`EV_BROWN] ##1 !ev[`EV_BROWN]
    ) else $error("brown-out event not raised");
    AST_HW_WINS: assert property (
        ev[`EV_WDR] && wr_flags && wdat[`BIT_WDT] |=> !flags_r[`BIT_WDT]
    ) else $error("firmware write beat hardware");

endmodule : reset_cause_recorder

`default_nettype wire

// ===== rcr_src_model.sv
`timescale 1ns/1ps
`default_nettype none

module rcr_src_model (
    // System
    input  wire logic               clk_i,
    // Reset sources
    output logic                    brownout_det_o,
    output logic                    low_power_brownout_o,
    output logic                    external_reset_pin_n_o,
    output var rcr_pkg::core_evt_s  core_o
);
    logic       asleep_r;
    logic [4:0] pulse_r;

    // Pulse order: watchdog, irq wake, instruction, overflow, underflow
    assign core_o = {asleep_r, pulse_r};

    initial begin
        asleep_r               = 1'b0;
        pulse_r                = 5'h00;
        brownout_det_o         = 1'b0;
        low_power_brownout_o   = 1'b0;
        external_reset_pin_n_o = 1'b1;
    end

    // Core strobes last exactly one cycle; a wake ends the sleep
    task automatic fire(input logic [4:0] v);
        @(posedge clk_i);
        pulse_r <= v;
        @(posedge clk_i);
        pulse_r <= 5'h00;
        if (v[4] || v[3]) begin
            asleep_r <= 1'b0;
        end
    endtask : fire

    task automatic nap(input logic v);
        @(posedge clk_i);
        asleep_r <= v;
    endtask : nap

    // Pin has a pull-up, so it idles high between resets
    task automatic pin(input int n);
        @(posedge clk_i);
        external_reset_pin_n_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        external_reset_pin_n_o <= 1'b1;
        asleep_r               <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask : pin

    task automatic brown(input logic lp, input int n);
        @(posedge clk_i);
        brownout_det_o       <= !lp;
        low_power_brownout_o <= lp;
        repeat (n) @(posedge clk_i);
        brownout_det_o       <= 1'b0;
        low_power_brownout_o <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask : brown
endmodule : rcr_src_model

`default_nettype wire

// ===== reset_cause_recorder_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcr_params.svh"

module reset_cause_recorder_tb;
    localparam logic [4:0] P_WDT = 5'h10;
    localparam logic [4:0] P_IRQ = 5'h08;
    localparam logic [4:0] P_INS = 5'h04;
    localparam logic [4:0] P_OVF = 5'h02;
    localparam logic [4:0] P_UNF = 5'h01;

    logic               clk_i = 1'b0;
    logic               rst_i = 1'b1;
    logic               cyc_i = 1'b0;
    logic               stb_i = 1'b0;
    logic               we_i  = 1'b0;
    logic [7:0]         adr_i = 8'h00;
    logic [3:0]         sel_i = 4'h0;
    logic [31:0]        dat_i = 32'h00000000;
    logic               sre   = 1'b1;
    logic               irq_en = 1'b0;
    logic [3:0]         lanes = 4'h1;
    logic [31:0]        dat_o;
    logic               ack_o;
    logic               bo_det;
    logic               bo_lp;
    logic               pin_n;
    rcr_pkg::core_evt_s core;
    logic [7:0]         flags_o;
    logic               to_o;
    logic               pwrdn_o;
    rcr_pkg::pc_ctl_s   pc_ctl;
    logic               irq_o;
    logic [7:0]         ef;
    logic               eto;
    logic               epd;
    int                 n_mismatch = 0;
    int                 checked    = 0;
    int                 cycles     = 0;

    always #50 clk_i = ~clk_i;

    rcr_src_model i_src (
        .clk_i                  (clk_i),
        .brownout_det_o         (bo_det),
        .low_power_brownout_o   (bo_lp),
        .external_reset_pin_n_o (pin_n),
        .core_o                 (core)
    );

    reset_cause_recorder i_dut (
        .clk_i                  (clk_i),
        .rst_i                  (rst_i),
        .cyc_i                  (cyc_i),
        .stb_i                  (stb_i),
        .we_i                   (we_i),
        .adr_i                  (adr_i),
        .sel_i                  (sel_i),
        .dat_i                  (dat_i),
        .dat_o                  (dat_o),
        .ack_o                  (ack_o),
        .brownout_det_i         (bo_det),
        .low_power_brownout_i   (bo_lp),
        .external_reset_pin_n_i (pin_n),
        .core_i                 (core),
        .stack_reset_enable_i   (sre),
        .global_irq_enable_i    (irq_en),
        .flags_o                (flags_o),
        .time_out_bit_o         (to_o),
        .power_down_bit_o       (pwrdn_o),
        .pc_ctl_o               (pc_ctl),
        .irq_o                  (irq_o)
    );

    // ------------------------------------------------------------------
    // Compare and bus tasks
    // ------------------------------------------------------------------
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk_pc(input rcr_pkg::pc_action_e a,
                          input logic [15:0] ad);
        logic bad;
        checked++;
        bad = (pc_ctl.action !== a);
        if (a == rcr_pkg::ACT_ZERO || a == rcr_pkg::ACT_VEC) begin
            bad = bad || (pc_ctl.addr !== ad);
        end
        if (bad) begin
            n_mismatch++;
            $display("[FAIL] %0t restart control %h", $time, pc_ctl);
        end
    endtask : chk_pc

    task automatic chk_state();
        chk8(flags_o, ef);
        chk8({6'h00, to_o, pwrdn_o}, {6'h00, eto, epd});
    endtask : chk_state

    task automatic chk_irq(input logic e);
        #1;
        chk8({7'h00, irq_o}, {7'h00, e});
    endtask : chk_irq

    // Holds the request until ack is sampled high at an edge
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= lanes;
        dat_i <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        q = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        if (n >= 20) begin
            n_mismatch++;
            $display("[FAIL] %0t no bus answer", $time);
            stop_test();
        end
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        wb(1'b0, a, 8'h00, q);
        chk8(q, exp);
    endtask : rd

    task automatic ev(input logic [4:0] v, input rcr_pkg::pc_action_e a,
                      input logic [15:0] ad);
        i_src.fire(v);
        #1;
        chk_pc(a, ad);
        chk_state();
    endtask : ev

    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    // A hang counts as a mismatch
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            stop_test();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        ef  = `FLAGS_RST;
        eto = 1'b1;
        epd = 1'b1;
        @(posedge clk_i);
        #1;
        chk_state();
        rd(`OFS_FLAGS, 8'h1c);
        rd(`OFS_STATUS, 8'h18);
        rd(`OFS_MASK, 8'h00);
        // A write with the low byte lane off must leave the mask alone
        lanes = 4'h0;
        wr(`OFS_MASK, 8'hff);
        lanes = 4'h1;
        rd(`OFS_MASK, 8'h00);
        rd(8'h20, 8'h00);
        wr(`OFS_FLAGS, 8'hff);
        ef = 8'hdf;
        rd(`OFS_FLAGS, 8'hdf);
        ef[`BIT_INSTR] = 1'b0;
        ev(P_INS, rcr_pkg::ACT_ZERO, `VEC_RESET);
        rd(`OFS_EVT, 8'h20);
        chk_irq(1'b0);
        wr(`OFS_MASK, 8'h20);
        chk_irq(1'b1);
        wr(`OFS_EVT, 8'h20);
        chk_irq(1'b0);
        ef[`BIT_WDT] = 1'b0;
        eto = 1'b0;
        ev(P_WDT, rcr_pkg::ACT_ZERO, `VEC_RESET);
        wr(`OFS_FLAGS, 8'h1f);
        ef = 8'h1f;
        rd(`OFS_FLAGS, 8'h1f);
        @(posedge clk_i);
        sre <= 1'b0;
        ev(P_OVF, rcr_pkg::ACT_IDLE, 16'h0000);
        ev(P_UNF, rcr_pkg::ACT_IDLE, 16'h0000);
        @(posedge clk_i);
        sre <= 1'b1;
        ef = 8'h9f;
        ev(P_OVF, rcr_pkg::ACT_ZERO, `VEC_RESET);
        ef = 8'hdf;
        ev(P_UNF, rcr_pkg::ACT_ZERO, `VEC_RESET);
        ef = 8'hdb;
        ev(P_INS, rcr_pkg::ACT_ZERO, `VEC_RESET);
        i_src.brown(1'b0, 6);
        ef  = 8'h1e;
        eto = 1'b1;
        #1;
        chk_state();
        wr(`OFS_FLAGS, 8'h1f);
        ef  = 8'h0f;
        eto = 1'b0;
        ev(P_WDT, rcr_pkg::ACT_ZERO, `VEC_RESET);
        i_src.brown(1'b1, 6);
        ef  = 8'h0e;
        eto = 1'b1;
        #1;
        chk_state();
        i_src.nap(1'b1);
        eto = 1'b0;
        epd = 1'b0;
        ev(P_WDT, rcr_pkg::ACT_NEXT, 16'h0000);
        i_src.nap(1'b1);
        eto = 1'b1;
        ev(P_IRQ, rcr_pkg::ACT_NEXT, 16'h0000);
        i_src.nap(1'b1);
        irq_en <= 1'b1;
        ev(P_IRQ, rcr_pkg::ACT_VEC, `VEC_IRQ);
        ev(P_IRQ, rcr_pkg::ACT_IDLE, 16'h0000);
        i_src.pin(6);
        ef = 8'h06;
        #1;
        chk_state();
        wr(`OFS_FLAGS, 8'h0f);
        ef  = 8'h0f;
        eto = 1'b0;
        i_src.nap(1'b1);
        ev(P_WDT, rcr_pkg::ACT_NEXT, 16'h0000);
        i_src.nap(1'b1);
        i_src.pin(6);
        ef  = 8'h07;
        eto = 1'b1;
        #1;
        chk_state();
        wr(`OFS_FLAGS, 8'h1f);
        ef  = 8'h0b;
        eto = 1'b0;
        ev(P_WDT | P_INS, rcr_pkg::ACT_ZERO, `VEC_RESET);
        rd(`OFS_EVT, 8'hff);
        rd(`OFS_LAST, 8'h22);
        chk_irq(1'b1);
        stop_test();
    end
endmodule : reset_cause_recorder_tb

`default_nettype wire
